// *** rtl/pid_process_controller.sv ***
// closed-loop process controller with apb settings
`timescale 1ns/1ps
`default_nettype none
`include "pid_regs.svh"
module pid_process_controller
#(
    parameter int SAMPLE_CYCLES = `PID_SAMPLE_CYCLES
)
(
    input wire logic clk,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [15:0] pid_setpoint,
    input wire logic [15:0] second_analog_input,
    output logic signed [31:0] pid_output,
    output logic pid_output_valid,
    output logic pid_active,
    output logic add_to_reference
);
    // ************************************************************
    // settings
    // ************************************************************
    logic [15:0] controller_function_select;
    logic [15:0] proportional_gain;
    logic [15:0] integral_time;
    logic [15:0] integrator_clamp;
    logic [15:0] derivative_time;
    logic [15:0] output_clamp;
    logic signed [15:0] output_offset;
    logic [15:0] output_filter_time_constant;
    logic [15:0] output_polarity_select;
    logic [15:0] output_gain;

    function automatic logic [15:0] cap(input logic [31:0] v,
                                        input logic [15:0] mx);
        cap = (v > {16'h0, mx}) ? mx : v[15:0];
    endfunction

    wire wr = psel && penable && pwrite;
    wire [31:0] offs_lo = 32'(-$signed({16'h0, `PID_PCT_MAX}));
    wire offs_hi = $signed(pwdata) > $signed({16'h0, `PID_PCT_MAX});
    wire offs_low = $signed(pwdata) < $signed(offs_lo);
    wire [15:0] offs_w = offs_hi ? `PID_PCT_MAX :
                         offs_low ? offs_lo[15:0] : pwdata[15:0];

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            controller_function_select <= `PID_FUNC_RST;
            proportional_gain <= `PID_KP_RST;
            integral_time <= `PID_TI_RST;
            integrator_clamp <= `PID_ILIM_RST;
            derivative_time <= `PID_TD_RST;
            output_clamp <= `PID_OLIM_RST;
            output_offset <= `PID_OFFS_RST;
            output_filter_time_constant <= `PID_TF_RST;
            output_polarity_select <= `PID_POL_RST;
            output_gain <= `PID_GAIN_RST;
        end
        else if (wr)
        begin
            case (paddr)
                `PID_ADDR_FUNC:
                    controller_function_select <= cap(pwdata, `PID_FUNC_MAX);
                `PID_ADDR_KP: proportional_gain <= cap(pwdata, `PID_GAIN_MAX);
                `PID_ADDR_TI: integral_time <= cap(pwdata, `PID_TI_MAX);
                `PID_ADDR_ILIM: integrator_clamp <= cap(pwdata, `PID_PCT_MAX);
                `PID_ADDR_TD: derivative_time <= cap(pwdata, `PID_TIME10_MAX);
                `PID_ADDR_OLIM: output_clamp <= cap(pwdata, `PID_PCT_MAX);
                `PID_ADDR_OFFS: output_offset <= offs_w;
                `PID_ADDR_TF:
                    output_filter_time_constant <=
                        cap(pwdata, `PID_TIME10_MAX);
                `PID_ADDR_POL: output_polarity_select <= {15'h0, pwdata[0]};
                `PID_ADDR_GAIN: output_gain <= cap(pwdata, `PID_GAIN_MAX);
                default: ;
            endcase
        end
    end

    // ************************************************************
    // apb read side
    // ************************************************************
    logic signed [31:0] integ;
    wire mapped = paddr[1:0] == 2'h0 && paddr <= `PID_ADDR_INTEG;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;
    always_comb
    begin
        case (paddr)
            `PID_ADDR_FUNC: prdata = {16'h0, controller_function_select};
            `PID_ADDR_KP: prdata = {16'h0, proportional_gain};
            `PID_ADDR_TI: prdata = {16'h0, integral_time};
            `PID_ADDR_ILIM: prdata = {16'h0, integrator_clamp};
            `PID_ADDR_TD: prdata = {16'h0, derivative_time};
            `PID_ADDR_OLIM: prdata = {16'h0, output_clamp};
            `PID_ADDR_OFFS: prdata = 32'(output_offset);
            `PID_ADDR_TF: prdata = {16'h0, output_filter_time_constant};
            `PID_ADDR_POL: prdata = {16'h0, output_polarity_select};
            `PID_ADDR_GAIN: prdata = {16'h0, output_gain};
            `PID_ADDR_OUT: prdata = pid_output;
            `PID_ADDR_INTEG: prdata = integ;
            default: prdata = 32'h0;
        endcase
    end

    // ************************************************************
    // mode decode and sample tick
    // ************************************************************
    wire enabled = controller_function_select != 16'h0;
    wire d_feedback = controller_function_select[0];
    wire reverse = output_polarity_select[0];
    assign pid_active = enabled;
    assign add_to_reference = controller_function_select[2] ||
                              controller_function_select == 16'h3;

    logic [31:0] tick_cnt;
    wire tick = tick_cnt == 32'(SAMPLE_CYCLES - 1);
    always_ff @(posedge clk)
    begin
        if (reset || tick)
            tick_cnt <= 32'h0;
        else
            tick_cnt <= tick_cnt + 32'h1;
    end

    // ************************************************************
    // computation sequence
    // ************************************************************
    pid_pkg::pid_state_e state;
    logic signed [17:0] err;
    logic signed [31:0] p_term;
    logic signed [40:0] isum;
    logic signed [17:0] d_prev;
    logic signed [47:0] d_term;
    logic signed [47:0] y_acc;
    logic div_start;
    logic signed [47:0] div_num;
    logic [23:0] div_den;
    logic signed [47:0] div_q;
    logic div_done;
    logic div_busy;

    wire signed [17:0] fb = $signed({2'h0, second_analog_input});
    wire signed [17:0] sp = $signed({2'h0, pid_setpoint});
    wire signed [17:0] err_raw = sp - fb;
    wire signed [17:0] err_pol = reverse ? -err_raw : err_raw;
    wire signed [17:0] d_raw = d_feedback ? -fb : sp;
    wire signed [17:0] d_src = reverse ? -d_raw : d_raw;
    wire signed [17:0] d_diff = d_src - d_prev;
    wire [23:0] ti_den = 24'(integral_time) * 24'(`PID_TI_SCALE);
    wire signed [40:0] ilim = 41'(integrator_clamp) * 41'(`PID_PCT_SCALE);
    wire signed [40:0] ilim_sum = ilim * $signed({17'h0, ti_den});
    wire signed [47:0] olim = 48'(output_clamp) * 48'(`PID_PCT_SCALE);
    wire signed [47:0] offs = 48'(output_offset) * 48'(`PID_PCT_SCALE);
    wire signed [47:0] total = 48'(p_term) + 48'(integ) + d_term;
    wire signed [47:0] clamped = total > olim ? olim :
                                 total < -olim ? -olim : total;
    wire signed [47:0] pre = clamped + offs;
    wire signed [47:0] y_val = y_acc >>> `PID_FILT_FRAC;
    // gain widened as signed so a negative output keeps its sign
    wire signed [63:0] gained = 64'(y_val) * $signed(64'(output_gain)) /
                                64'(`PID_GAIN_UNIT);
    wire signed [31:0] out_sat = gained > 64'sh7FFFFFFF ? 32'sh7FFFFFFF :
                                 gained < -64'sh80000000 ? 32'sh80000000 :
                                 gained[31:0];
    wire [23:0] tf_den = 24'(output_filter_time_constant) *
                         24'(`PID_T10_SCALE) + 24'h1;

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            state <= pid_pkg::S_IDLE;
            err <= 18'sh0;
            p_term <= 32'sh0;
            integ <= 32'sh0;
            isum <= 41'sh0;
            d_prev <= 18'sh0;
            d_term <= 48'sh0;
            y_acc <= 48'sh0;
            pid_output <= 32'sh0;
            pid_output_valid <= 1'b0;
            div_start <= 1'b0;
            div_num <= 48'sh0;
            div_den <= 24'h0;
        end
        else
        begin
            pid_output_valid <= 1'b0;
            div_start <= 1'b0;
            case (state)
                pid_pkg::S_IDLE:
                begin
                    // wait out a division left over from an abandoned sample
                    if (tick && enabled && !div_busy)
                        state <= pid_pkg::S_ERR;
                end
                pid_pkg::S_ERR:
                begin
                    err <= err_pol;
                    p_term <= 32'(err_pol) * $signed(32'(proportional_gain)) /
                              32'(`PID_GAIN_UNIT);
                    isum <= isum + 41'(err_pol);
                    state <= pid_pkg::S_INT;
                end
                pid_pkg::S_INT:
                begin
                    d_term <= (derivative_time == 16'h0) ? 48'sh0 :
                              48'(d_diff) * 48'(derivative_time) *
                              48'(`PID_T10_SCALE);
                    d_prev <= d_src;
                    if (integral_time == 16'h0)
                    begin
                        integ <= 32'sh0;
                        isum <= 41'sh0;
                        state <= pid_pkg::S_SUM;
                    end
                    else
                    begin
                        div_num <= 48'(isum);
                        div_den <= ti_den;
                        div_start <= 1'b1;
                        state <= pid_pkg::S_IWAIT;
                    end
                end
                pid_pkg::S_IWAIT:
                begin
                    if (div_done)
                    begin
                        if (div_q > 48'(ilim))
                        begin
                            integ <= 32'(ilim);
                            isum <= ilim_sum;
                        end
                        else if (div_q < -48'(ilim))
                        begin
                            integ <= 32'(-ilim);
                            isum <= -ilim_sum;
                        end
                        else
                            integ <= div_q[31:0];
                        state <= pid_pkg::S_SUM;
                    end
                end
                pid_pkg::S_SUM:
                begin
                    div_num <= (pre <<< `PID_FILT_FRAC) - y_acc;
                    div_den <= tf_den;
                    div_start <= 1'b1;
                    state <= pid_pkg::S_FWAIT;
                end
                pid_pkg::S_FWAIT:
                begin
                    if (div_done)
                    begin
                        y_acc <= y_acc + div_q;
                        state <= pid_pkg::S_GAIN;
                    end
                end
                pid_pkg::S_GAIN:
                begin
                    pid_output <= out_sat;
                    pid_output_valid <= 1'b1;
                    state <= pid_pkg::S_IDLE;
                end
                default: state <= pid_pkg::S_IDLE;
            endcase
            // a disabled controller drops any sample in flight
            if (!enabled)
            begin
                state <= pid_pkg::S_IDLE;
                integ <= 32'sh0;
                isum <= 41'sh0;
                y_acc <= 48'sh0;
                pid_output <= 32'sh0;
                pid_output_valid <= 1'b0;
            end
        end
    end

    pid_divider divider
    (
        .clk(clk),
        .reset(reset),
        .start(div_start),
        .numerator(div_num),
        .denominator(div_den),
        .quotient(div_q),
        .busy(div_busy),
        .done(div_done)
    );
endmodule
`default_nettype wire

// *** rtl/pid_regs.svh ***
// register offsets, reset values, ranges and timing of the process controller
`ifndef PID_REGS_SVH
`define PID_REGS_SVH

`define PID_ADDR_FUNC 8'h00
`define PID_ADDR_KP 8'h04
`define PID_ADDR_TI 8'h08
`define PID_ADDR_ILIM 8'h0C
`define PID_ADDR_TD 8'h10
`define PID_ADDR_OLIM 8'h14
`define PID_ADDR_OFFS 8'h18
`define PID_ADDR_TF 8'h1C
`define PID_ADDR_POL 8'h20
`define PID_ADDR_GAIN 8'h24
`define PID_ADDR_OUT 8'h28
`define PID_ADDR_INTEG 8'h2C

`define PID_FUNC_MAX 16'h0004
`define PID_GAIN_MAX 16'h09C4
`define PID_TI_MAX 16'h0E10
`define PID_PCT_MAX 16'h03E8
`define PID_TIME10_MAX 16'h03E8

`define PID_FUNC_RST 16'h0000
`define PID_KP_RST 16'h0064
`define PID_TI_RST 16'h000A
`define PID_ILIM_RST 16'h03E8
`define PID_TD_RST 16'h0000
`define PID_OLIM_RST 16'h03E8
`define PID_OFFS_RST 16'h0000
`define PID_TF_RST 16'h0000
`define PID_POL_RST 16'h0000
`define PID_GAIN_RST 16'h0064

`define PID_GAIN_UNIT 100
`define PID_PCT_SCALE 10
`define PID_TI_SCALE 100
`define PID_T10_SCALE 10
`define PID_FILT_FRAC 8

`define PID_SAMPLE_NS 1000000
`define PID_CLK_NS 5
`define PID_SAMPLE_CYCLES (`PID_SAMPLE_NS / `PID_CLK_NS)

`endif

// *** rtl/pid_pkg.sv ***
// types shared by the process controller
package pid_pkg;
    typedef enum logic [2:0] {
        S_IDLE = 3'h0,
        S_ERR = 3'h1,
        S_INT = 3'h3,
        S_IWAIT = 3'h2,
        S_SUM = 3'h6,
        S_FWAIT = 3'h7,
        S_GAIN = 3'h5
    } pid_state_e;
endpackage

// *** rtl/pid_divider.sv ***
// sequential signed-by-unsigned divider with registered quotient
`timescale 1ns/1ps
`default_nettype none
module pid_divider
(
    input wire logic clk,
    input wire logic reset,
    input wire logic start,
    input wire logic signed [47:0] numerator,
    input wire logic [23:0] denominator,
    output logic signed [47:0] quotient,
    output logic busy,
    output logic done
);
    logic [47:0] mag;
    logic [23:0] rem;
    logic [23:0] den;
    logic [5:0] cnt;
    logic neg;
    wire [24:0] rem_w = {rem, mag[47]};
    wire take = rem_w >= {1'b0, den};
    wire [24:0] rem_sub = rem_w - {1'b0, den};
    wire [23:0] rem_nx = take ? rem_sub[23:0] : rem_w[23:0];
    wire [47:0] mag_nx = {mag[46:0], take};
    wire [47:0] num_abs = numerator[47] ? 48'(-numerator) : numerator;

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            mag <= 48'h0;
            rem <= 24'h0;
            den <= 24'h0;
            cnt <= 6'h0;
            neg <= 1'b0;
            busy <= 1'b0;
            done <= 1'b0;
            quotient <= 48'sh0;
        end
        else if (start && !busy)
        begin
            mag <= num_abs;
            rem <= 24'h0;
            den <= (denominator == 24'h0) ? 24'h1 : denominator;
            cnt <= 6'h30;
            neg <= numerator[47];
            busy <= 1'b1;
            done <= 1'b0;
        end
        else if (busy)
        begin
            mag <= mag_nx;
            rem <= rem_nx;
            cnt <= cnt - 6'h1;
            if (cnt == 6'h1)
            begin
                busy <= 1'b0;
                done <= 1'b1;
                quotient <= neg ? 48'(-$signed(mag_nx)) : $signed(mag_nx);
            end
        end
        else
        begin
            done <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// *** bench/pid_process_controller_asserts.sv ***
// port assertions for the process controller
`timescale 1ns/1ps
`default_nettype none
module pid_process_controller_asserts
(
    input wire logic clk,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [15:0] pid_setpoint,
    input wire logic [15:0] second_analog_input,
    input wire logic signed [31:0] pid_output,
    input wire logic pid_output_valid,
    input wire logic pid_active,
    input wire logic add_to_reference
);
    // ****************************************
    // properties
    // ****************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    wire logic acc = psel && penable;
    wire logic fwr = acc && pwrite && (paddr == 8'h00);
    property p_ready; acc |-> pready; endproperty
    a_ready: assert property (p_ready)
        else $error("pready low in access");
    property p_unmapped; acc && (paddr > 8'h2C) |-> pslverr && prdata == 0;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped access not refused");
    property p_func_off; fwr && pwdata[15:0] == 16'h0000 |=> !pid_active;
    endproperty
    a_func_off: assert property (p_func_off)
        else $error("function 0 left controller active");
    property p_func_add;
        fwr && pwdata[15:0] == 16'h0003 |=> pid_active && add_to_reference;
    endproperty
    a_func_add: assert property (p_func_add)
        else $error("function 3 not decoded");
    property p_add_act; add_to_reference |-> pid_active; endproperty
    a_add_act: assert property (p_add_act)
        else $error("add to reference while disabled");
    property p_quiet;
        (!pid_active)[*3] |-> !pid_output_valid && pid_output == 0;
    endproperty
    a_quiet: assert property (p_quiet)
        else $error("disabled controller produced output");
    property p_pulse; pid_output_valid |=> (!pid_output_valid)[*8];
    endproperty
    a_pulse: assert property (p_pulse)
        else $error("valid not a single pulse per sample");
    property p_hold;
        $changed(pid_output) |-> pid_output_valid || !$past(pid_active);
    endproperty
    a_hold: assert property (p_hold)
        else $error("output changed between samples");
    c_valid: cover property (pid_output_valid);
    c_err: cover property (acc && pslverr);
    c_add: cover property (add_to_reference && pid_output_valid);
endmodule
bind pid_process_controller pid_process_controller_asserts chk
(
    .clk(clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pid_setpoint(pid_setpoint),
    .second_analog_input(second_analog_input), .pid_output(pid_output),
    .pid_output_valid(pid_output_valid), .pid_active(pid_active),
    .add_to_reference(add_to_reference)
);
`default_nettype wire

// *** bench/pid_process_controller_tb.sv ***
// self-checking bench for the process controller
`timescale 1ns/1ps
`default_nettype none
`include "pid_regs.svh"
module pid_process_controller_tb;
    localparam int SC = 300;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [15:0] sp = 16'h1388;
    logic [15:0] fb = 16'h0BB8;
    logic [31:0] prdata;
    logic pready, pslverr, pid_output_valid, pid_active, add_to_reference;
    logic signed [31:0] pid_output;
    int err_total = 0;
    int checks_done = 0;
    logic [31:0] cfgv [10];
    pid_process_controller #(.SAMPLE_CYCLES(SC)) uut
    (
        .clk(clk), .reset(reset), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .pid_setpoint(sp),
        .second_analog_input(fb), .pid_output(pid_output),
        .pid_output_valid(pid_output_valid), .pid_active(pid_active),
        .add_to_reference(add_to_reference)
    );
    initial
    begin
        forever #2.5 clk = ~clk;
    end
    // ****************************************
    // shared tasks
    // ****************************************
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        checks_done++;
        if (g !== e)
        begin
            err_total++;
            $display("Error %s expected %0h got %0h", nm, e, g);
        end
    endtask
    task automatic chkb(input string nm, input logic c);
        chk(nm, 32'h1, {31'h0, c});
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic er);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        logic e;
        apb(1'b1, a, d, x, e);
    endtask
    task automatic rdchk(input string nm, input logic [7:0] a,
                         input logic [31:0] ev, input logic ee);
        logic [31:0] x;
        logic e;
        apb(1'b0, a, 32'h0, x, e);
        chk(nm, ev, x);
        chkb("pslverr", e === ee);
    endtask
    task automatic samp(input int n);
        int k;
        repeat (n)
        begin
            k = 0;
            @(posedge clk);
            while (pid_output_valid !== 1'b1 && k < 2 * SC)
            begin
                @(posedge clk);
                k++;
            end
            chkb("valid", pid_output_valid);
        end
    endtask
    task automatic base();
        cfgv = '{32'h1, 32'h64, 32'h0, 32'h3E8, 32'h0, 32'h3E8, 32'h0,
                 32'h0, 32'h0, 32'h64};
    endtask
    task automatic apply();
        wr(8'h00, 32'h0);
        for (int i = 1; i < 10; i++)
            wr(8'(i * 4), cfgv[i]);
        wr(8'h00, cfgv[0]);
    endtask
    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_regs();
        logic [15:0] df [10] = '{`PID_FUNC_RST, `PID_KP_RST, `PID_TI_RST,
            `PID_ILIM_RST, `PID_TD_RST, `PID_OLIM_RST, `PID_OFFS_RST,
            `PID_TF_RST, `PID_POL_RST, `PID_GAIN_RST};
        logic [15:0] mx [10] = '{`PID_FUNC_MAX, `PID_GAIN_MAX, `PID_TI_MAX,
            `PID_PCT_MAX, `PID_TIME10_MAX, `PID_PCT_MAX, `PID_PCT_MAX,
            `PID_TIME10_MAX, 16'h0001, `PID_GAIN_MAX};
        chk("out_rst", 32'h0, pid_output);
        for (int i = 0; i < 10; i++)
            rdchk("reg_rst", 8'(i * 4), {16'h0, df[i]}, 1'b0);
        for (int i = 1; i < 10; i++)
            if (i != 8)
            begin
                wr(8'(i * 4), 32'h7FFF);
                rdchk("reg_sat", 8'(i * 4), {16'h0, mx[i]}, 1'b0);
            end
        wr(`PID_ADDR_OUT, 32'h1234);
        rdchk("ro_out", `PID_ADDR_OUT, 32'h0, 1'b0);
        rdchk("unmapped", 8'h30, 32'h0, 1'b1);
        rdchk("misaligned", 8'h06, 32'h0, 1'b1);
        for (int m = 0; m < 6; m++)
        begin
            wr(8'h00, 32'(m));
            @(posedge clk);
            chkb("active", pid_active === (m != 0));
            chkb("add_ref", add_to_reference === (m > 2));
        end
    endtask
    task automatic t_prop();
        logic [3:0] ia [11] = '{1, 1, 1, 8, 9, 9, 5, 6, 6, 5, 0};
        logic [31:0] va [11] = '{32'h64, 32'hFA, 32'h0, 32'h1, 32'hC8, 32'h0,
            32'h64, 32'h32, 32'hFFFFFFCE, 32'h64, 32'h3};
        logic [3:0] ib [11] = '{0, 0, 0, 0, 0, 0, 0, 0, 0, 6, 0};
        logic [31:0] ex [11] = '{32'h7D0, 32'h1388, 32'h0, 32'hFFFFF830,
            32'hFA0, 32'h0, 32'h3E8, 32'h9C4, 32'h5DC, 32'h5DC, 32'h7D0};
        for (int c = 0; c < 11; c++)
        begin
            base();
            cfgv[ia[c]] = va[c];
            if (ib[c] != 0)
                cfgv[ib[c]] = 32'h32;
            apply();
            samp(2);
            chk("pid_out", ex[c], pid_output);
        end
        chkb("add_ref", add_to_reference);
    endtask
    task automatic t_integ();
        logic signed [31:0] fast;
        base();
        cfgv[1] = 32'h0;
        cfgv[2] = 32'hA;
        apply();
        samp(10);
        fast = pid_output;
        cfgv[2] = 32'h14;
        apply();
        samp(10);
        chkb("integ_rate", fast > pid_output && pid_output > 0);
        cfgv[2] = 32'hA;
        cfgv[3] = 32'hA;
        apply();
        samp(60);
        chk("integ_clamp", 32'h64, pid_output);
        rdchk("integ_reg", `PID_ADDR_INTEG, 32'h64, 1'b0);
        cfgv[2] = 32'h0;
        apply();
        samp(3);
        chk("integ_off", 32'h0, pid_output);
    endtask
    task automatic t_deriv();
        base();
        cfgv[1] = 32'h0;
        cfgv[4] = 32'h1;
        apply();
        samp(2);
        fb <= 16'h0B54;
        samp(1);
        chk("d_fb", 32'h3E8, pid_output);
        samp(1);
        chk("d_settle", 32'h0, pid_output);
        cfgv[0] = 32'h2;
        apply();
        samp(2);
        fb <= 16'h0BB8;
        samp(1);
        chk("d_ff_fb", 32'h0, pid_output);
        sp <= 16'h13EC;
        samp(1);
        chk("d_ff_sp", 32'h3E8, pid_output);
        sp <= 16'h1388;
    endtask
    task automatic t_filt();
        base();
        cfgv[7] = 32'h1;
        apply();
        samp(1);
        chkb("filt", pid_output > 0 && pid_output < 32'sh7D0);
        wr(8'h00, 32'h0);
        repeat (4) @(posedge clk);
        chk("off_out", 32'h0, pid_output);
    endtask
    task automatic summarize();
        if (err_total == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial
    begin
        repeat (80000) @(posedge clk);
        err_total++;
        summarize();
    end
    initial
    begin
        repeat (8) @(posedge clk);
        reset <= 1'b0;
        t_regs();
        t_prop();
        t_integ();
        t_deriv();
        t_filt();
        summarize();
    end
endmodule
`default_nettype wire
